// ---- hdl/mbfh_handler.sv ----
// slave-side request handler: decodes a parsed request, checks
// limits, drives register accesses and streams the reply bytes.
// assumes framing and checksum are done outside; req_* are held
// while the request is valid; register port answers in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mbfh_defines.svh"

module mbfh_handler #(
  parameter int RESP_DELAY = `MBFH_RESP_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_broadcast,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_rd_addr,
  input wire logic [15:0] req_rd_count,
  input wire logic [15:0] req_wr_addr,
  input wire logic [15:0] req_wr_count,
  input wire logic [15:0] req_sub,
  input wire logic [15:0] req_data,
  input wire logic [15:0] wr_value,
  input wire logic [1:0] byte_order,
  input wire logic [15:0] diag_reg,
  input wire logic [15:0] reg_rdata,
  input wire logic tx_ready,
  output logic req_done,
  output logic wr_data_next,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic tx_valid,
  output logic tx_last,
  output logic [7:0] tx_data
);

  // ==========================================================
  // request decode
  mbfh_pkg::mbfh_state_e state;
  logic is_read;
  logic is_diag;
  logic writes;
  logic reads;
  logic bad_func;
  logic bad_count;
  logic bad_bcast;
  logic [7:0] exc_code;

  // 03 and 04 share one path
  assign is_read = (req_func == `MBFH_FC_RD_HOLD) ||
                   (req_func == `MBFH_FC_RD_INPUT); // RL2
  assign is_diag = req_func == `MBFH_FC_DIAG;
  assign writes = (req_func == `MBFH_FC_WR_SINGLE) ||
                  (req_func == `MBFH_FC_WR_MULTI) ||
                  (req_func == `MBFH_FC_RW_MULTI);
  assign reads = is_read || (req_func == `MBFH_FC_RW_MULTI);
  assign bad_func = !(is_read || writes ||
                      (is_diag && ((req_sub == `MBFH_DIAG_LOOPBACK) ||
                       (req_sub == `MBFH_DIAG_REGISTER)))); // RL5 RL6
  assign bad_bcast = req_broadcast && !writes; // RL10

  // count limits per function code
  always_comb begin
    bad_count = 1'b0;
    case (req_func)
      `MBFH_FC_RD_HOLD, `MBFH_FC_RD_INPUT:
        bad_count = (req_rd_count == 16'h0000) ||
                    (req_rd_count > {8'h00, `MBFH_MAX_RD}); // RL3
      `MBFH_FC_WR_MULTI:
        bad_count = (req_wr_count == 16'h0000) ||
                    (req_wr_count > {8'h00, `MBFH_MAX_WR}); // RL7
      `MBFH_FC_RW_MULTI:
        bad_count = (req_wr_count == 16'h0000) ||
                    (req_rd_count == 16'h0000) ||
                    (req_wr_count > {8'h00, `MBFH_MAX_RW}) ||
                    (req_rd_count > {8'h00, `MBFH_MAX_RW}); // RL8
      default: bad_count = 1'b0;
    endcase
  end

  assign exc_code = bad_func ? `MBFH_EXC_FUNC : `MBFH_EXC_VALUE;

  // ==========================================================
  // reply buffer: words read back or echoed
  logic [15:0] rbuf [0:127];
  logic [7:0] idx;
  logic [7:0] nwords;
  logic [31:0] wait_cnt;
  logic half;
  logic [7:0] sel_idx;
  logic sel_half;
  logic [15:0] sel_word;
  logic [7:0] ordered;

  // byte to load next: the current slot before the first load, then
  // the slot after the byte being accepted, so none goes out twice
  assign sel_half = tx_valid ? !half : half;
  assign sel_idx = (tx_valid && half) ? idx + 8'h01 : idx;
  assign sel_word = rbuf[sel_idx[6:0]];

  mbfh_byte_order u_order (
    .word(sel_word),
    .order(byte_order),
    .second(sel_half),
    .tx_byte(ordered)
  );

  // ==========================================================
  // sequence control
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= mbfh_pkg::MBFH_IDLE;
      idx <= 8'h00;
      nwords <= 8'h00;
      wait_cnt <= 32'h0000_0000;
      half <= 1'b0;
    end else begin
      case (state)
        mbfh_pkg::MBFH_IDLE: begin
          if (req_valid) begin
            state <= mbfh_pkg::MBFH_CHECK;
          end
        end
        mbfh_pkg::MBFH_CHECK: begin
          idx <= 8'h00;
          half <= 1'b0;
          wait_cnt <= 32'h0000_0000;
          if (bad_func || bad_count || bad_bcast) begin
            nwords <= 8'h01; // RL17
            state <= req_broadcast ? mbfh_pkg::MBFH_DONE :
                                     mbfh_pkg::MBFH_WAIT; // RL18
          end else if (writes) begin
            state <= mbfh_pkg::MBFH_WRITE; // RL9
          end else if (reads) begin
            state <= mbfh_pkg::MBFH_READ;
          end else begin
            nwords <= 8'h01;
            state <= mbfh_pkg::MBFH_WAIT;
          end
        end
        mbfh_pkg::MBFH_WRITE: begin
          idx <= idx + 8'h01;
          if ((req_func == `MBFH_FC_WR_SINGLE) ||
              ({8'h00, idx} == req_wr_count - 16'h0001)) begin // RL4
            idx <= 8'h00;
            if (req_broadcast) begin
              state <= mbfh_pkg::MBFH_DONE; // RL18
            end else if (req_func == `MBFH_FC_RW_MULTI) begin
              state <= mbfh_pkg::MBFH_READ; // RL9
            end else begin
              nwords <= 8'h01;
              state <= mbfh_pkg::MBFH_WAIT;
            end
          end
        end
        mbfh_pkg::MBFH_READ: begin
          idx <= idx + 8'h01;
          if ({8'h00, idx} == req_rd_count - 16'h0001) begin // RL1
            nwords <= req_rd_count[7:0];
            idx <= 8'h00;
            state <= mbfh_pkg::MBFH_WAIT;
          end
        end
        mbfh_pkg::MBFH_WAIT: begin
          wait_cnt <= wait_cnt + 32'h0000_0001;
          if (wait_cnt >= RESP_DELAY - 1) begin
            state <= mbfh_pkg::MBFH_SEND; // RL11
          end
        end
        mbfh_pkg::MBFH_SEND: begin
          if (tx_valid && tx_ready) begin
            half <= !half;
            if (half) begin
              idx <= idx + 8'h01;
            end
            if (tx_last) begin
              state <= mbfh_pkg::MBFH_DONE;
            end
          end
        end
        mbfh_pkg::MBFH_DONE: begin
          if (!req_valid) begin
            state <= mbfh_pkg::MBFH_IDLE;
          end
        end
        default: state <= mbfh_pkg::MBFH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // reply buffer fill: read data, loopback echo, diag register
  always_ff @(posedge ref_clk) begin
    if (state == mbfh_pkg::MBFH_READ && reg_rd) begin
      rbuf[idx[6:0]] <= reg_rdata; // RL1
    end else if (state == mbfh_pkg::MBFH_CHECK) begin
      if (bad_func || bad_count || bad_bcast) begin
        rbuf[0] <= {`MBFH_EXC_FLAG | req_func, exc_code};
      end else if (is_diag && req_sub == `MBFH_DIAG_LOOPBACK) begin
        rbuf[0] <= req_data; // RL5
      end else if (is_diag) begin
        rbuf[0] <= diag_reg; // RL6
      end else if (writes) begin
        rbuf[0] <= req_wr_addr;
      end
    end
  end

  // ==========================================================
  // register port strobes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= 16'h0000;
      reg_wdata <= 16'h0000;
      wr_data_next <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      wr_data_next <= 1'b0;
      if (state == mbfh_pkg::MBFH_CHECK && !(bad_func || bad_count ||
          bad_bcast) && writes) begin
        reg_wr <= 1'b1;
        reg_addr <= req_wr_addr;
        reg_wdata <= (req_func == `MBFH_FC_WR_SINGLE) ? req_data :
                                                         wr_value;
        wr_data_next <= 1'b1;
      end else if (state == mbfh_pkg::MBFH_WRITE &&
                   req_func != `MBFH_FC_WR_SINGLE &&
                   {8'h00, idx} != req_wr_count - 16'h0001) begin
        reg_wr <= 1'b1; // RL7 RL8
        reg_addr <= req_wr_addr + {8'h00, idx} + 16'h0001;
        reg_wdata <= wr_value;
        wr_data_next <= 1'b1;
      end else if ((state == mbfh_pkg::MBFH_CHECK && !(bad_func ||
                   bad_count || bad_bcast) && !writes && reads) ||
                   (state == mbfh_pkg::MBFH_WRITE && !req_broadcast &&
                    req_func == `MBFH_FC_RW_MULTI &&
                    {8'h00, idx} == req_wr_count - 16'h0001)) begin
        reg_rd <= 1'b1; // RL9
        reg_addr <= req_rd_addr;
      end else if (state == mbfh_pkg::MBFH_READ &&
                   {8'h00, idx} != req_rd_count - 16'h0001) begin
        reg_rd <= 1'b1;
        reg_addr <= req_rd_addr + {8'h00, idx} + 16'h0001;
      end
    end
  end

  // ==========================================================
  // transmit stream; words packed high byte = byte one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_data <= 8'h00;
      req_done <= 1'b0;
    end else begin
      req_done <= (state == mbfh_pkg::MBFH_DONE) && req_valid;
      if (state == mbfh_pkg::MBFH_SEND && !(tx_valid && tx_ready &&
          tx_last)) begin
        tx_valid <= 1'b1;
        if (!tx_valid || tx_ready) begin
          // last when the slot loaded is the second byte of the last word
          tx_data <= ordered; // RL12 RL13 RL14 RL15 RL16
          tx_last <= tx_valid && !half && (idx == nwords - 8'h01);
        end
      end else begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- hdl/mbfh_defines.svh ----
// constants for the field-bus request handler: function codes,
// count limits, exception codes and reply timing.
// assumes a 200 MHz ref_clk; included by bare name.
//
// Overview of operation
// RL1: read holding returns addressed consecutive registers
// RL2: read input behaves exactly like read holding
// RL3: reads cover at most 125 registers
// RL4: write single updates exactly one register
// RL5: diagnostics sub-function zero echoes query data
// RL6: diagnostics sub-function two returns diagnostics register
// RL7: write multiple covers at most 120 registers
// RL8: read/write multiple covers at most 118 registers
// RL9: combined request writes before it reads
// RL10: broadcast allowed only for codes 06, 16, 23
// RL11: reply starts 3 to 5 ms after request
// RL12: floats are IEEE 754 over two registers
// RL13: float high byte holds sign and exponent
// RL14: integer: byte one high, byte zero low
// RL15: strings pack two bytes per register, high first
// RL16: transmit byte order configurable, default 1-0-3-2
// RL17: bad code or count gives exception reply
// RL18: broadcasts are executed but never answered
`ifndef MBFH_DEFINES_SVH
`define MBFH_DEFINES_SVH

`define MBFH_FC_RD_HOLD 8'h03
`define MBFH_FC_RD_INPUT 8'h04
`define MBFH_FC_WR_SINGLE 8'h06
`define MBFH_FC_DIAG 8'h08
`define MBFH_FC_WR_MULTI 8'h10
`define MBFH_FC_RW_MULTI 8'h17

`define MBFH_DIAG_LOOPBACK 16'h0000
`define MBFH_DIAG_REGISTER 16'h0002

`define MBFH_MAX_RD 8'h7d
`define MBFH_MAX_WR 8'h78
`define MBFH_MAX_RW 8'h76

`define MBFH_EXC_FUNC 8'h01
`define MBFH_EXC_ADDR 8'h02
`define MBFH_EXC_VALUE 8'h03
`define MBFH_EXC_FLAG 8'h80

`define MBFH_CLK_MHZ 200
`define MBFH_RESP_MIN_MS 3
`define MBFH_RESP_MAX_MS 5
`define MBFH_RESP_MIN_CYC (`MBFH_RESP_MIN_MS * 1000 * `MBFH_CLK_MHZ)

`define MBFH_ORDER_1032 2'h0
`define MBFH_ORDER_0123 2'h1
`define MBFH_ORDER_2301 2'h2
`define MBFH_ORDER_3210 2'h3

`endif

// ---- hdl/mbfh_pkg.sv ----
// types shared by the request handler files.
// assumes mbfh_defines.svh for the numeric constants.
`default_nettype none
package mbfh_pkg;

  // handler sequence, one-hot
  typedef enum logic [6:0] {
    MBFH_IDLE = 7'h01,
    MBFH_CHECK = 7'h02,
    MBFH_WRITE = 7'h04,
    MBFH_READ = 7'h08,
    MBFH_WAIT = 7'h10,
    MBFH_SEND = 7'h20,
    MBFH_DONE = 7'h40
  } mbfh_state_e;

  typedef logic [15:0] mbfh_word_t;

endpackage
`default_nettype wire

// ---- hdl/mbfh_byte_order.sv ----
// orders the two bytes of one outgoing register word.
// assumes the word holds byte one in its high half.
`timescale 1ns/1ps
`default_nettype none
`include "mbfh_defines.svh"

module mbfh_byte_order (
  input wire logic [15:0] word,
  input wire logic [1:0] order,
  input wire logic second,
  output logic [7:0] tx_byte
);

  // orders 1-0-3-2 and 3-2-1-0 send the high byte first
  always_comb begin
    if ((order == `MBFH_ORDER_1032) || (order == `MBFH_ORDER_3210)) begin
      tx_byte = second ? word[7:0] : word[15:8]; // RL16
    end else begin
      tx_byte = second ? word[15:8] : word[7:0];
    end
  end

endmodule
`default_nettype wire

// ---- bench/mbfh_checker.sv ----
// port assertions for the request handler.
// assumes mbfh_handler as the top; bound after the module.
`timescale 1ns/1ps
`default_nettype none

module mbfh_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_broadcast,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_rd_count,
  input wire logic [15:0] req_wr_count,
  input wire logic [15:0] req_data,
  input wire logic tx_ready,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  logic rd_seen;
  logic f_ok;
  logic f_bc;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // helper logic
  // remembers a read strobe within the current request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rd_seen <= 1'b0;
    else rd_seen <= req_valid && (rd_seen || reg_rd);
  end
  assign f_ok = req_func inside {8'h03, 8'h04, 8'h06, 8'h08, 8'h10, 8'h17};
  assign f_bc = req_func inside {8'h06, 8'h10, 8'h17};
  // ==========================================
  // assertions
  rd_limit_a: assert property (
    req_valid && req_func inside {8'h03, 8'h04} && req_rd_count > 16'h007d
    |-> !reg_rd) else $error("read over limit accessed");
  wr_limit_a: assert property (
    req_valid && req_func == 8'h10 && req_wr_count > 16'h0078
    |-> !reg_wr) else $error("write over limit accessed");
  rw_limit_a: assert property (
    req_valid && req_func == 8'h17 && req_wr_count > 16'h0076
    |-> !reg_wr && !reg_rd) else $error("combined over limit accessed");
  bad_func_a: assert property (
    req_valid && !f_ok |-> !reg_wr && !reg_rd)
    else $error("unknown code accessed");
  bc_func_a: assert property (
    req_valid && req_broadcast && !f_bc |-> !reg_wr && !reg_rd)
    else $error("refused broadcast accessed");
  bc_quiet_a: assert property (
    req_valid && req_broadcast |-> !tx_valid)
    else $error("broadcast answered");
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte dropped");
  single_data_a: assert property (
    req_valid && req_func == 8'h06 && reg_wr |-> reg_wdata == req_data)
    else $error("single write value wrong");
  write_first_a: assert property (
    rd_seen |-> !reg_wr) else $error("write after read");
  cover property (req_func == 8'h17 && reg_rd);
  cover property (tx_valid && !tx_ready);
  cover property (req_broadcast && reg_wr);
endmodule

bind mbfh_handler mbfh_checker u_chk (.ref_clk, .nrst, .req_valid,
  .req_broadcast, .req_func, .req_rd_count, .req_wr_count, .req_data,
  .tx_ready, .reg_wr, .reg_rd, .reg_wdata, .tx_valid, .tx_data);

`default_nettype wire

// ---- bench/mbfh_partner.sv ----
// register store and reply byte sink beside the handler.
// assumes read data answers within the strobe cycle; stall halves
// the sink rate.
`timescale 1ns/1ps
`default_nettype none

module mbfh_partner (
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [7:0] tx_data,
  output logic [15:0] reg_rdata,
  output logic tx_ready
);
  logic [15:0] mem [256];
  logic [7:0] rx_q [$];
  logic tick = 1'b0;
  int last_pos = -1;
  // ==========================================
  // store and sink
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
  end
  assign tx_ready = !stall || tick;
  // idle read data is inverted so stale values never look valid
  assign reg_rdata = reg_rd ? mem[reg_addr[7:0]] : ~mem[reg_addr[7:0]];
  // last_pos keeps the index of the byte that came with the end mark
  always @(posedge ref_clk) begin
    tick <= !tick;
    if (reg_wr) mem[reg_addr[7:0]] <= reg_wdata;
    if (tx_valid && tx_ready) begin
      if (tx_last) last_pos <= rx_q.size();
      rx_q.push_back(tx_data);
    end
  end
endmodule

`default_nettype wire

// ---- bench/mbfh_handler_test.sv ----
// self-checking bench for the request handler.
// assumes mbfh_partner as register store and byte sink.
`timescale 1ns/1ps
`default_nettype none

module mbfh_handler_test;
  logic ref_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0;
  logic req_broadcast = 1'b0, stall = 1'b0;
  logic [7:0] req_func = 8'h00;
  logic [15:0] req_rd_addr = '0, req_rd_count = '0, req_wr_addr = '0;
  logic [15:0] req_wr_count = '0, req_sub = '0, req_data = '0;
  logic [15:0] wr_value = '0, diag_reg = '0, reg_rdata, reg_addr, reg_wdata;
  logic [1:0] byte_order = 2'h0;
  logic req_done, wr_data_next, reg_wr, reg_rd, tx_ready, tx_valid;
  logic tx_last;
  logic [7:0] tx_data;
  logic [7:0] eq [$];
  int miscompares = 0, num_checks = 0;
  int lat = 0;
  // ==========================================
  // clock, write data source, instances
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (wr_data_next) wr_value <= wr_value + 16'h1111;
  mbfh_handler #(.RESP_DELAY(4)) u_dut (.ref_clk, .nrst, .req_valid,
    .req_broadcast, .req_func, .req_rd_addr, .req_rd_count, .req_wr_addr,
    .req_wr_count, .req_sub, .req_data, .wr_value, .byte_order, .diag_reg,
    .reg_rdata, .tx_ready, .req_done, .wr_data_next, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .tx_valid, .tx_last, .tx_data);
  mbfh_partner u_partner (.ref_clk, .stall, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .tx_valid, .tx_last, .tx_data, .reg_rdata, .tx_ready);
  // ==========================================
  // shared tasks
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // expected bytes of one reply word in the selected order
  task ew(input logic [15:0] w);
    if (byte_order == 2'h0 || byte_order == 2'h3) begin
      eq.push_back(w[15:8]);
      eq.push_back(w[7:0]);
    end else begin
      eq.push_back(w[7:0]);
      eq.push_back(w[15:8]);
    end
  endtask
  task cmp_reply;
    chk(16'(u_partner.rx_q.size()), 16'(eq.size()));
    chk(16'(u_partner.last_pos), 16'(eq.size() - 1));
    foreach (eq[i]) chk({8'h00, u_partner.rx_q[i]}, {8'h00, eq[i]});
  endtask
  // presents one request, waits for done, then withdraws it
  task run(input logic [7:0] f, input logic [15:0] ra, rc, wa, wc);
    int n;
    req_func = f;
    req_rd_addr = ra;
    req_rd_count = rc;
    req_wr_addr = wa;
    req_wr_count = wc;
    eq.delete();
    u_partner.rx_q.delete();
    u_partner.last_pos = -1;
    lat = 0;
    req_valid = 1'b1;
    n = 0;
    while (req_done !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
      if (tx_valid === 1'b1 && lat == 0) lat = n;
    end
    if (n == 3000) begin
      miscompares++;
      report_and_stop;
    end
    req_valid = 1'b0;
    req_broadcast = 1'b0;
    @(negedge ref_clk);
  endtask
  // ==========================================
  // scenarios
  task t_limits;
    run(8'h03, '0, 16'h007d, '0, '0);
    for (int i = 0; i < 125; i++) ew({i[7:0], ~i[7:0]});
    cmp_reply;
    run(8'h03, '0, 16'h007e, '0, '0);
    ew(16'h8303);
    cmp_reply;
    run(8'h10, '0, '0, '0, 16'h0079);
    ew(16'h9003);
    cmp_reply;
    run(8'h17, '0, 16'h0001, '0, 16'h0077);
    ew(16'h9703);
    cmp_reply;
    run(8'h05, '0, 16'h0001, '0, '0);
    ew(16'h8501);
    cmp_reply;
    $display("limits done");
  endtask
  task t_diag;
    req_data = 16'h12ab;
    req_sub = 16'h0000;
    for (int o = 0; o < 4; o++) begin
      byte_order = o[1:0];
      run(8'h08, '0, '0, '0, '0);
      ew(16'h12ab);
      cmp_reply;
      // request, decode, four delay cycles, then the first byte stands
      chk(16'(lat), 16'h0007);
    end
    byte_order = 2'h0;
    diag_reg = 16'h5a3c;
    req_sub = 16'h0002;
    run(8'h08, '0, '0, '0, '0);
    ew(16'h5a3c);
    cmp_reply;
    $display("diag done");
  endtask
  // float, string and integer words go out register by register
  task t_types;
    u_partner.mem[64] = 16'h0000; // float, bytes one and zero
    u_partner.mem[65] = 16'hc148; // float, sign and exponent byte high
    u_partner.mem[66] = 16'h4142; // four-byte string, byte three first
    u_partner.mem[67] = 16'h4344;
    u_partner.mem[68] = 16'h1234; // integer
    byte_order = 2'h0;
    run(8'h03, 16'h0040, 16'h0005, '0, '0);
    ew(16'h0000);
    ew(16'hc148);
    ew(16'h4142);
    ew(16'h4344);
    ew(16'h1234);
    cmp_reply;
    chk({8'h00, u_partner.rx_q[2]}, 16'h00c1);
    chk({8'h00, u_partner.rx_q[8]}, 16'h0012);
    $display("types done");
  endtask
  task t_write;
    req_data = 16'hbeef;
    run(8'h06, '0, '0, 16'h0005, 16'h0001);
    ew(16'h0005);
    cmp_reply;
    chk(u_partner.mem[5], 16'hbeef);
    chk(u_partner.mem[6], 16'h06f9);
    wr_value = 16'h1111;
    stall = 1'b1;
    run(8'h10, '0, '0, 16'h000a, 16'h0002);
    stall = 1'b0;
    ew(16'h000a);
    cmp_reply;
    chk(u_partner.mem[11], 16'h2222);
    wr_value = 16'h3333;
    run(8'h17, 16'h0014, 16'h0001, 16'h0014, 16'h0001);
    ew(16'h3333);
    cmp_reply;
    run(8'h03, 16'h000a, 16'h0002, '0, '0);
    ew(16'h1111);
    ew(16'h2222);
    cmp_reply;
    run(8'h04, 16'h000a, 16'h0002, '0, '0);
    ew(16'h1111);
    ew(16'h2222);
    cmp_reply;
    $display("write done");
  endtask
  task t_bcast;
    req_broadcast = 1'b1;
    req_data = 16'hcafe;
    run(8'h06, '0, '0, 16'h0030, 16'h0001);
    cmp_reply;
    chk(u_partner.mem[48], 16'hcafe);
    req_broadcast = 1'b1;
    run(8'h03, '0, 16'h0001, '0, '0);
    cmp_reply;
    $display("broadcast done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    t_limits;
    t_types;
    t_diag;
    t_write;
    t_bcast;
    report_and_stop;
  end
endmodule

`default_nettype wire
